// [design/rbs_pkg.sv]
package rbs_pkg;
   // Ratio inputs are unsigned Q16.16
   localparam int unsigned RATIO_FRAC   = 16;
   localparam logic [15:0] TORQUE_DFLT  = 16'h012C;
   localparam logic [31:0] DROOP_DFLT   = 32'h0063_FF9C;
   localparam logic [31:0] POS_RST      = 32'h0000_0000;
   // Pi in Q16.16 times sixty seconds per minute
   localparam logic [23:0] PI_MIN_Q16   = 24'hBC_7EDD;
   // L unit scaling folded with x100 storage scale, same divisor for every unit
   localparam logic [6:0]  MON_DIV      = 7'h64;
   localparam int unsigned NUM_W        = 72;
   localparam int unsigned DEN_W        = 40;
   localparam logic [6:0]  DIV_STEPS    = 7'h48;
   localparam logic [31:0] MON_SAT      = 32'h7FFF_FFFF;

   typedef enum logic [1:0] {
      RBS_MM    = 2'h0,
      RBS_INCH  = 2'h1,
      RBS_DEG   = 2'h2,
      RBS_PULSE = 2'h3
   } rbs_unit_t;

   typedef enum logic [1:0] {
      RBS_ST_REAL = 2'b01,
      RBS_ST_VIRT = 2'b10
   } rbs_state_t;

   typedef struct packed {
      logic        is_roller;
      rbs_unit_t   out_unit;
      rbs_unit_t   real_unit;
      logic [31:0] roller_diam;
      logic [31:0] pulses_per_roller_turn;
      logic [31:0] droop_limit;
      logic [31:0] axis_speed_ceiling;
      logic [15:0] backlash;
      logic        torque_dev_assigned;
   } rbs_cfg_t;

   typedef struct packed {
      logic signed [31:0] speed;
      logic signed [31:0] travel;
   } rbs_motion_t;
endpackage : rbs_pkg

// [design/rbs_axis.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Roller command scaled by gear and change ratio
// - Drive motion passes only with clutch engaged
// - Roller position kept as signed 32-bit ring
// - Backlash compensation runs in both modes
// - Cycle speed from pulses, pi, diameter, pulses
// - Monitor stored integer, one x100 scale for mm and inch alike
// - Droop overrun sets flag, motion continues
// - Speed overrun sets flag, no clamping
// - Torque limit enforced, default 300 percent
// - Diameter and pulses only affect the monitor
// - Monitor shares feed position storage
// - Ball screw command scaled by gear only
// - Ball screw position carried across modes
// - Roller mm or inch, any real unit
// - Settings latched at switch except backlash, torque each cycle
// - Ball screw unit mismatch rejects switch
module rbs_axis
   import rbs_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Operation cycle and mode control
   input  wire logic               op_tick,
   input  wire logic               virt_req,
   input  wire logic               err_clr,
   // Configuration and transmission
   input  wire rbs_cfg_t           cfg,
   input  wire logic        [31:0] gear_ratio,
   input  wire logic        [31:0] change_ratio,
   input  wire logic               clutch_on,
   input  wire logic        [15:0] torque_dev,
   // Motion sources
   input  wire rbs_motion_t        drive,
   input  wire logic signed [31:0] real_travel,
   input  wire logic signed [31:0] deviation,
   // Servo command
   output rbs_motion_t             cmd_q,
   output logic             [15:0] torque_limit_q,
   // Status
   output logic signed      [31:0] pos_mon_q,
   output logic                    axis_error_flag_q,
   output logic                    mode_err_q,
   output logic                    virtual_q
);
   rbs_state_t         state_q;
   rbs_cfg_t           cfg_q;
   logic signed [31:0] ring_q;
   logic signed [31:0] feed_q;
   logic               dir_neg_q;
   logic               dir_valid_q;
   logic        [NUM_W-1:0] num_q;
   logic        [DEN_W:0]   rem_q;
   logic        [DEN_W-1:0] den_q;
   logic        [6:0]       div_cnt_q;
   logic               div_busy_q;

   logic signed [63:0] sp_gear;
   logic signed [63:0] sp_full;
   logic signed [63:0] tr_gear;
   logic signed [63:0] tr_full;
   logic signed [31:0] speed_d;
   logic signed [31:0] travel_d;
   logic signed [31:0] travel_bl;
   logic signed [31:0] src_travel;
   logic        [31:0] abs_speed;
   logic        [31:0] abs_dev;
   logic        [63:0] prod_sl;
   logic        [87:0] prod_num;
   logic        [DEN_W:0] rem_sh;
   logic               go_virt;
   logic               unit_bad;
   logic               tick_v;
   logic               reverse;

   assign tick_v = op_tick && (state_q == RBS_ST_VIRT);

   always_comb begin
      sp_gear = (64'(drive.speed) * $signed({32'h0, gear_ratio}))
                >>> RATIO_FRAC;
      tr_gear = (64'(drive.travel) * $signed({32'h0, gear_ratio}))
                >>> RATIO_FRAC;
      // Part-select drops the sign, so restore it before widening
      sp_full = (64'($signed(sp_gear[31:0]))
                 * $signed({32'h0, change_ratio})) >>> RATIO_FRAC;
      tr_full = (64'($signed(tr_gear[31:0]))
                 * $signed({32'h0, change_ratio})) >>> RATIO_FRAC;
   end

   always_comb begin
      if (!clutch_on) begin
         speed_d  = 32'sh0;
         travel_d = 32'sh0;
      end else if (cfg_q.is_roller) begin
         speed_d  = sp_full[31:0];
         travel_d = tr_full[31:0];
      end else begin
         speed_d  = sp_gear[31:0];
         travel_d = tr_gear[31:0];
      end
   end

   // Source travel depends on mode; backlash follows either
   assign src_travel = (state_q == RBS_ST_VIRT) ? travel_d : real_travel;
   assign reverse    = dir_valid_q && (src_travel != 32'sh0) &&
                       (src_travel[31] != dir_neg_q);

   always_comb begin
      travel_bl = src_travel;
      if (reverse) begin
         if (src_travel[31]) begin
            travel_bl = src_travel - $signed({16'h0, cfg.backlash});
         end else begin
            travel_bl = src_travel + $signed({16'h0, cfg.backlash});
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dir_neg_q   <= 1'b0;
         dir_valid_q <= 1'b0;
      end else if (op_tick && (src_travel != 32'sh0)) begin
         dir_neg_q   <= src_travel[31];
         dir_valid_q <= 1'b1;
      end
   end

   assign unit_bad = !cfg.is_roller && (cfg.out_unit != cfg.real_unit);
   assign go_virt  = op_tick && virt_req && (state_q == RBS_ST_REAL);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= RBS_ST_REAL;
      end else begin
         case (state_q)
            RBS_ST_REAL: begin
               if (go_virt && !unit_bad) begin
                  state_q <= RBS_ST_VIRT;
               end
            end
            RBS_ST_VIRT: begin
               if (op_tick && !virt_req) begin
                  state_q <= RBS_ST_REAL;
               end
            end
            default: state_q <= RBS_ST_REAL;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_err_q <= 1'b0;
      end else if (go_virt && unit_bad) begin
         mode_err_q <= 1'b1;
      end else if (err_clr) begin
         mode_err_q <= 1'b0;
      end
   end

   // Mirrors the state flop so the mode output is registered
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         virtual_q <= 1'b0;
      end else if (go_virt && !unit_bad) begin
         virtual_q <= 1'b1;
      end else if (tick_v && !virt_req) begin
         virtual_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= '0;
      end else if (go_virt && !unit_bad) begin
         cfg_q <= cfg;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         torque_limit_q <= TORQUE_DFLT;
      end else if ((go_virt && !unit_bad) || tick_v) begin
         torque_limit_q <= cfg.torque_dev_assigned ? torque_dev
                                                   : TORQUE_DFLT;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_q <= '0;
      end else if (op_tick) begin
         cmd_q.speed  <= virtual_q ? speed_d : 32'sh0;
         cmd_q.travel <= travel_bl;
      end
   end

   assign abs_speed = speed_d[31] ? 32'(-speed_d) : 32'(speed_d);
   assign abs_dev   = deviation[31] ? 32'(-deviation) : 32'(deviation);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         axis_error_flag_q <= 1'b0;
      end else if (virtual_q && ((abs_dev > cfg_q.droop_limit) ||
                   (abs_speed > cfg_q.axis_speed_ceiling))) begin
         axis_error_flag_q <= 1'b1;
      end else if (err_clr) begin
         axis_error_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ring_q <= POS_RST;
      end else if (go_virt) begin
         ring_q <= feed_q;
      end else if (tick_v) begin
         ring_q <= ring_q + travel_bl;
      end
   end

   // ball screw feed continues in both modes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         feed_q <= POS_RST;
      end else if (tick_v && !cfg_q.is_roller) begin
         feed_q <= feed_q + travel_bl;
      end else if (op_tick && virt_req == 1'b0 && virtual_q) begin
         feed_q <= cfg_q.is_roller ? ring_q + travel_bl : feed_q;
      end else if (op_tick && !virtual_q) begin
         feed_q <= feed_q + travel_bl;
      end
   end

   assign prod_sl  = 64'(abs_speed) * 64'(cfg_q.roller_diam);
   assign prod_num = 88'(prod_sl) * 88'(PI_MIN_Q16);
   assign rem_sh   = {rem_q[DEN_W-1:0], num_q[NUM_W-1]};

   // Serial divider keeps area small; needs 72 clocks per cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         num_q      <= '0;
         rem_q      <= '0;
         den_q      <= '0;
         div_cnt_q  <= 7'h00;
         div_busy_q <= 1'b0;
      end else if (tick_v && cfg_q.is_roller) begin
         num_q      <= prod_num[NUM_W+15:16];
         rem_q      <= '0;
         den_q      <= DEN_W'(cfg_q.pulses_per_roller_turn) *
                       DEN_W'(MON_DIV);
         div_cnt_q  <= DIV_STEPS;
         div_busy_q <= 1'b1;
      end else if (div_busy_q) begin
         if (rem_sh >= {1'b0, den_q}) begin
            rem_q <= rem_sh - {1'b0, den_q};
            num_q <= {num_q[NUM_W-2:0], 1'b1};
         end else begin
            rem_q <= rem_sh;
            num_q <= {num_q[NUM_W-2:0], 1'b0};
         end
         div_cnt_q  <= div_cnt_q - 7'h01;
         div_busy_q <= (div_cnt_q != 7'h01);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pos_mon_q <= POS_RST;
      end else if (virtual_q && cfg_q.is_roller) begin
         if (div_busy_q && div_cnt_q == 7'h01) begin
            // Quotient at or past bit 31 saturates instead of wrapping
            if (|num_q[NUM_W-2:30]) begin
               pos_mon_q <= MON_SAT;
            end else begin
               pos_mon_q <= $signed({num_q[30:0],
                                     rem_sh >= {1'b0, den_q}});
            end
         end
      end else begin
         pos_mon_q <= feed_q;
      end
   end
endmodule : rbs_axis

// [verification/rbs_axis_monitor.sv]
`timescale 1ns/10ps
module rbs_axis_monitor
   import rbs_pkg::*;
(
   // Clock and control
   input wire logic               core_clk,
   input wire logic               rst,
   input wire logic               op_tick,
   input wire logic               virt_req,
   input wire logic               err_clr,
   input wire logic               clutch_on,
   // Setup and motion
   input wire rbs_cfg_t           cfg,
   input wire logic        [31:0] gear_ratio,
   input wire logic        [31:0] change_ratio,
   input wire logic        [15:0] torque_dev,
   input wire rbs_motion_t        drive,
   input wire logic signed [31:0] deviation,
   // Outputs
   input wire rbs_motion_t        cmd_q,
   input wire logic        [15:0] torque_limit_q,
   input wire logic               axis_error_flag_q,
   input wire logic               mode_err_q,
   input wire logic               virtual_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Leaving ticks excluded, their outputs are not pinned down
   wire logic tv = op_tick && virtual_q && virt_req;
   wire logic bad_u = !cfg.is_roller && cfg.out_unit != cfg.real_unit;
   wire logic unity = gear_ratio == 32'h0001_0000
      && (!cfg.is_roller || change_ratio == 32'h0001_0000);
   scale_pass_a: assert property (
      tv && clutch_on && unity |=> cmd_q.speed == $past(drive.speed))
      else $error("unity ratio speed wrong");
   clutch_gate_a: assert property (
      tv && !clutch_on && cfg.backlash == 16'h0000 |=> cmd_q == '0)
      else $error("motion passed with clutch open");
   torque_load_a: assert property (
      tv |=> torque_limit_q == ($past(cfg.torque_dev_assigned) ?
      $past(torque_dev) : TORQUE_DFLT)) else $error("torque limit wrong");
   droop_flag_a: assert property (
      tv && !deviation[31] && deviation > cfg.droop_limit
      |-> ##[1:3] axis_error_flag_q) else $error("droop not flagged");
   speed_flag_a: assert property (
      tv && clutch_on && unity && !drive.speed[31]
      && drive.speed > cfg.axis_speed_ceiling |-> ##[1:3] axis_error_flag_q)
      else $error("overspeed not flagged");
   flag_hold_a: assert property (
      axis_error_flag_q && !err_clr |=> axis_error_flag_q)
      else $error("error flag dropped");
   unit_refuse_a: assert property (
      op_tick && virt_req && !virtual_q && bad_u |=> mode_err_q && !virtual_q)
      else $error("unit mismatch not refused");
   mode_enter_a: assert property (
      op_tick && virt_req && !virtual_q && !bad_u |=> virtual_q)
      else $error("virtual mode not entered");
   cover property (tv && !clutch_on);
   cover property (mode_err_q);
   cover property (axis_error_flag_q && virtual_q);
endmodule : rbs_axis_monitor

bind rbs_axis rbs_axis_monitor rbs_axis_monitor_i (
   .core_clk(core_clk), .rst(rst), .op_tick(op_tick), .virt_req(virt_req),
   .err_clr(err_clr), .clutch_on(clutch_on), .cfg(cfg),
   .gear_ratio(gear_ratio), .change_ratio(change_ratio),
   .torque_dev(torque_dev), .drive(drive), .deviation(deviation),
   .cmd_q(cmd_q), .torque_limit_q(torque_limit_q),
   .axis_error_flag_q(axis_error_flag_q), .mode_err_q(mode_err_q),
   .virtual_q(virtual_q));

// [verification/rbs_servo_model.sv]
`timescale 1ns/10ps
module rbs_servo_model
   import rbs_pkg::*;
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Command in, droop out
   input  wire logic               op_tick,
   input  wire rbs_motion_t        cmd,
   input  wire logic               stall,
   output logic signed      [31:0] deviation_q
);
   // A stalled motor leaves every commanded pulse in the counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         deviation_q <= 32'sh0;
      end else if (op_tick) begin
         deviation_q <= stall ? deviation_q + cmd.travel : 32'sh0;
      end
   end
endmodule : rbs_servo_model

// [verification/rbs_axis_test.sv]
`timescale 1ns/10ps
module rbs_axis_test
   import rbs_pkg::*;
;
   typedef struct packed {
      logic        roller;
      logic        clutch;
      logic [31:0] gear;
      logic [31:0] change;
      rbs_motion_t drv;
      rbs_motion_t exp;
   } rbs_row_t;
   logic               core_clk = 1'b0;
   logic               rst      = 1'b1;
   logic               op_tick  = 1'b0;
   logic               virt_req = 1'b0;
   logic               err_clr  = 1'b0;
   logic               clutch   = 1'b1;
   logic               stall    = 1'b0;
   rbs_cfg_t           cfg      = '0;
   logic        [31:0] gear     = 32'h0001_0000;
   logic        [31:0] change   = 32'h0001_0000;
   logic        [15:0] tq_dev   = 16'h0000;
   rbs_motion_t        drive    = '0;
   logic signed [31:0] real_tr  = 32'sh0;
   logic signed [31:0] dev;
   rbs_motion_t        cmd_q;
   logic        [15:0] tq_q;
   logic signed [31:0] mon_q;
   logic               flag_q;
   logic               merr_q;
   logic               virt_q;
   int                 bad_count = 0;
   int                 tests_run = 0;
   rbs_row_t           rows [4];

   rbs_axis rbs_axis_i (.core_clk(core_clk), .rst(rst), .op_tick(op_tick),
      .virt_req(virt_req), .err_clr(err_clr), .cfg(cfg), .gear_ratio(gear),
      .change_ratio(change), .clutch_on(clutch), .torque_dev(tq_dev),
      .drive(drive), .real_travel(real_tr), .deviation(dev), .cmd_q(cmd_q),
      .torque_limit_q(tq_q), .pos_mon_q(mon_q), .axis_error_flag_q(flag_q),
      .mode_err_q(merr_q), .virtual_q(virt_q));
   rbs_servo_model rbs_servo_model_i (.core_clk(core_clk), .rst(rst),
      .op_tick(op_tick), .cmd(cmd_q), .stall(stall), .deviation_q(dev));

   always #4 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      tests_run++;
      if (seen !== expv) begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, expv);
      end
   endtask : check

   // Spacing leaves room for the monitor division
   task automatic tick(input logic vreq);
      @(negedge core_clk);
      virt_req = vreq;
      op_tick  = 1'b1;
      @(negedge core_clk);
      op_tick = 1'b0;
      repeat (76) @(negedge core_clk);
   endtask : tick

   task automatic enter(input logic rl, input rbs_unit_t ou, rbs_unit_t ru);
      tick(1'b0);
      cfg.is_roller = rl;
      cfg.out_unit  = ou;
      cfg.real_unit = ru;
      tick(1'b1);
   endtask : enter

   task automatic final_report();
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   initial begin
      #400000ns;
      bad_count++;
      final_report();
   end

   initial begin
      cfg.roller_diam            = 32'h0000_2710;
      cfg.pulses_per_roller_turn = 32'h0000_03E8;
      cfg.droop_limit            = DROOP_DFLT;
      cfg.axis_speed_ceiling     = 32'h7FFF_FFFF;
      rows[0] = '{1'b0, 1'b1, 32'h0002_0000, 32'h0003_0000,
         {32'h0000_0064, 32'h0000_000A}, {32'h0000_00C8, 32'h0000_0014}};
      rows[1] = '{1'b1, 1'b1, 32'h0002_0000, 32'h0003_0000,
         {32'h0000_0064, 32'h0000_000A}, {32'h0000_0258, 32'h0000_003C}};
      rows[2] = '{1'b1, 1'b0, 32'h0002_0000, 32'h0003_0000,
         {32'h0000_0064, 32'h0000_000A}, 64'h0};
      rows[3] = '{1'b1, 1'b1, 32'h0001_0000, 32'h0000_8000,
         {32'hFFFF_FFD8, 32'hFFFF_FFF8}, {32'hFFFF_FFEC, 32'hFFFF_FFFC}};
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      check({16'h0000, tq_q}, 32'h0000_012C);
      check({31'h0, flag_q}, 32'h0);
      $display("Reset test done");
      for (int i = 0; i < 4; i++) begin
         gear   = rows[i].gear;
         change = rows[i].change;
         clutch = rows[i].clutch;
         enter(rows[i].roller, RBS_MM, RBS_MM);
         drive = rows[i].drv;
         tick(1'b1);
         check(cmd_q.speed, rows[i].exp.speed);
         check(cmd_q.travel, rows[i].exp.travel);
         $display("Row %0d done", i);
      end
      gear   = 32'h0001_0000;
      change = 32'h0001_0000;
      clutch = 1'b1;
      cfg.torque_dev_assigned = 1'b1;
      // torque values kept 1 to 1000
      tq_dev = 16'h03E8;
      enter(1'b1, RBS_MM, RBS_MM);
      check({16'h0000, tq_q}, 32'h0000_03E8);
      tq_dev = 16'h0001;
      tick(1'b1);
      check({16'h0000, tq_q}, 32'h0000_0001);
      cfg.torque_dev_assigned = 1'b0;
      enter(1'b0, RBS_MM, RBS_MM);
      tick(1'b1);
      check({16'h0000, tq_q}, 32'h0000_012C);
      $display("Torque test done");
      cfg.axis_speed_ceiling = 32'h0000_0064;
      cfg.droop_limit        = 32'h0000_0010;
      enter(1'b1, RBS_INCH, RBS_MM);
      check({31'h0, virt_q}, 32'h1);
      drive = {32'h0000_0096, 32'h0000_0001};
      tick(1'b1);
      check(cmd_q.speed, 32'h0000_0096);
      check({31'h0, flag_q}, 32'h1);
      drive = {32'h0000_0001, 32'h0000_0020};
      tick(1'b1);
      check({31'h0, flag_q}, 32'h1);
      @(negedge core_clk);
      err_clr = 1'b1;
      @(negedge core_clk);
      err_clr = 1'b0;
      check({31'h0, flag_q}, 32'h0);
      stall = 1'b1;
      repeat (3) tick(1'b1);
      check({31'h0, flag_q}, 32'h1);
      check(cmd_q.travel, 32'h0000_0020);
      stall = 1'b0;
      $display("Error flag test done");
      enter(1'b0, RBS_MM, RBS_INCH);
      check({31'h0, merr_q}, 32'h1);
      check({31'h0, virt_q}, 32'h0);
      $display("Unit refusal test done");
      cfg.axis_speed_ceiling = 32'h7FFF_FFFF;
      cfg.droop_limit        = DROOP_DFLT;
      drive = {32'h0000_03E8, 32'h0000_0001};
      enter(1'b1, RBS_MM, RBS_MM);
      repeat (2) tick(1'b1);
      // Pi is truncated inside, one count either way is allowed
      check({31'h0, mon_q >= 18848 && mon_q <= 18850}, 32'h1);
      $display("Monitor test done");
      // Mid-run reset clears sticky flags and the position
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      check({16'h0000, tq_q}, 32'h0000_012C);
      check({31'h0, flag_q}, 32'h0);
      check({31'h0, merr_q}, 32'h0);
      check(mon_q, 32'h0000_0000);
      $display("Second reset test done");
      real_tr = 32'sh5;
      enter(1'b0, RBS_MM, RBS_MM);
      tick(1'b1);
      check(mon_q, 32'h0000_000B);
      cfg.backlash = 16'h0003;
      drive = {32'h0000_03E8, 32'hFFFF_FFFE};
      tick(1'b1);
      check(cmd_q.travel, 32'hFFFF_FFFB);
      tick(1'b0);
      check(mon_q, 32'h0000_0004);
      real_tr = 32'sh0;
      enter(1'b1, RBS_MM, RBS_MM);
      drive = {32'h0000_03E8, 32'h0000_0007};
      tick(1'b1);
      check(cmd_q.travel, 32'h0000_000A);
      tick(1'b0);
      check(mon_q, 32'h0000_0015);
      $display("Position carry test done");
      final_report();
   end
endmodule : rbs_axis_test
